// [logic/irq_ctl_pkg.sv]
// Shared constants for the interrupt control register pair and its controller
package irq_ctl_pkg;

  // ----------------------------------------------------------------
  // First register: enables and flags
  // ----------------------------------------------------------------
  localparam int unsigned GLOBAL_HIGH_BIT = 7;
  localparam int unsigned PERIPH_LOW_BIT = 6;
  localparam int unsigned TIMER_EN_BIT = 5;
  localparam int unsigned EXT0_EN_BIT = 4;
  localparam int unsigned PORT_EN_BIT = 3;
  localparam int unsigned TIMER_FLAG_BIT = 2;
  localparam int unsigned EXT0_FLAG_BIT = 1;
  localparam int unsigned PORT_FLAG_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Second register: pull-up, edge selects, priorities
  // ----------------------------------------------------------------
  localparam int unsigned PULLUP_BIT = 7;
  localparam int unsigned EDGE_PIN0_BIT = 6;
  localparam int unsigned TIMER_PRIO_BIT = 2;
  localparam int unsigned EXT3_PRIO_BIT = 1;
  localparam int unsigned PORT_PRIO_BIT = 0;
  localparam logic [7:0] EDGE_PRIO_RESET = 8'hFF;

  // ----------------------------------------------------------------
  // Vectors and link select codes
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_HIGH = 16'h0008;
  localparam logic [15:0] VEC_LOW = 16'h0018;
  localparam logic [15:0] VEC_NONE = 16'h0000;
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_EDGE = 2'h1;
  localparam logic [1:0] SEL_PORT = 2'h2;

  // ----------------------------------------------------------------
  // Controller register map (byte offsets) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CTRL_WIN = 8'h04;
  localparam logic [7:0] OFS_EDGE_WIN = 8'h08;
  localparam logic [7:0] OFS_PORT_RD = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_VECTOR = 8'h18;
  localparam int unsigned STATUS_HIGH_BIT = 0;
  localparam int unsigned STATUS_LOW_BIT = 1;
  localparam logic [1:0] STATUS_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_RD_REQ = 2'b10,
    ST_RD_WAIT = 2'b11
  } bus_state_e;

endpackage

// [logic/intr_link_if.sv]
// Link between the interrupt register block and its controller
`timescale 1ns/1ns
`default_nettype none
interface intr_link_if;
  logic priority_mode_enable;
  logic [1:0] reg_sel;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic irq_high;
  logic irq_low;
  logic [15:0] irq_vector;

  modport device_mp (
    input priority_mode_enable, reg_sel, reg_wr, reg_rd, reg_wdata,
    output reg_rdata, irq_high, irq_low, irq_vector
  );
  modport host_mp (
    output priority_mode_enable, reg_sel, reg_wr, reg_rd, reg_wdata,
    input reg_rdata, irq_high, irq_low, irq_vector
  );
endinterface
`default_nettype wire

// [logic/pin_sync.sv]
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second; nothing else may look at it
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// [logic/core_interrupt_control_regs.sv]
// Interrupt enable/flag and edge/priority registers with request logic
//
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module core_interrupt_control_regs (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  intr_link_if.device_mp link,
  input wire logic timer_ovf_i,
  input wire logic [3:0] ext_pin_i,
  input wire logic [3:0] upper_port_pins_i,
  input wire logic periph_req_i,
  input wire logic periph_high_i,
  output logic [2:0] ext_edge_o,
  output logic port_pullup_disable_o
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [7:0] pins_s;
  logic [3:0] ext_s;
  logic [3:0] port_s;
  logic [3:0] ext_prev_q;

  // Pins come from outside the clock domain
  pin_sync #(
    .WIDTH(8)
  ) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .async_i({upper_port_pins_i, ext_pin_i}),
    .sync_o(pins_s)
  );

  assign ext_s = pins_s[3:0];
  assign port_s = pins_s[7:4];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [4:0] enable_q;
  logic timer_flag_q;
  logic ext0_flag_q;
  logic port_flag_q;
  logic [7:0] edge_prio_q;
  logic [3:0] last_read_q;
  logic [7:0] rdata_q;
  logic irq_high_q;
  logic irq_low_q;
  logic [15:0] vector_q;

  logic wr_ctrl;
  logic wr_edge;
  logic rd_port;
  logic [3:0] rise_sel;
  logic [3:0] edge_hit;
  logic mismatch;

  // Host strobes decoded by select code
  assign wr_ctrl = link.reg_wr && (link.reg_sel == irq_ctl_pkg::SEL_CTRL);
  assign wr_edge = link.reg_wr && (link.reg_sel == irq_ctl_pkg::SEL_EDGE);
  assign rd_port = link.reg_rd && (link.reg_sel == irq_ctl_pkg::SEL_PORT);

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // Pin k's select sits at bit 6-k
  assign rise_sel = {edge_prio_q[irq_ctl_pkg::EDGE_PIN0_BIT-3],
                     edge_prio_q[irq_ctl_pkg::EDGE_PIN0_BIT-2],
                     edge_prio_q[irq_ctl_pkg::EDGE_PIN0_BIT-1],
                     edge_prio_q[irq_ctl_pkg::EDGE_PIN0_BIT]};

  // One-cycle hit per qualifying edge, compared against last sample
  assign edge_hit = (rise_sel & ext_s & ~ext_prev_q)
                  | (~rise_sel & ~ext_s & ext_prev_q);

  // Previous synchronised pin level
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_prev_q <= 4'h0;
    end else begin
      ext_prev_q <= ext_s;
    end
  end

  // Pins one to three have their flags elsewhere; pass their edges on
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_edge_o <= 3'h0;
    end else begin
      ext_edge_o <= edge_hit[3:1];
    end
  end

  // ----------------------------------------------------------------
  // First register: enables
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      enable_q <= irq_ctl_pkg::CTRL_RESET[7:3];
    end else if (wr_ctrl) begin
      enable_q <= link.reg_wdata[7:3];
    end
  end

  // ----------------------------------------------------------------
  // First register: flags
  // ----------------------------------------------------------------
  // Events win over a same-cycle software clear; enables never gate setting
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_flag_q <= irq_ctl_pkg::CTRL_RESET[irq_ctl_pkg::TIMER_FLAG_BIT];
    end else if (timer_ovf_i) begin
      timer_flag_q <= 1'b1;
    end else if (wr_ctrl) begin
      timer_flag_q <= link.reg_wdata[irq_ctl_pkg::TIMER_FLAG_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext0_flag_q <= irq_ctl_pkg::CTRL_RESET[irq_ctl_pkg::EXT0_FLAG_BIT];
    end else if (edge_hit[0]) begin
      ext0_flag_q <= 1'b1;
    end else if (wr_ctrl) begin
      ext0_flag_q <= link.reg_wdata[irq_ctl_pkg::EXT0_FLAG_BIT];
    end
  end

  // Mismatch against the last read keeps forcing the flag
  assign mismatch = (port_s != last_read_q);

  // Bit 0 has no defined power-on value; zero is used here
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      port_flag_q <= irq_ctl_pkg::CTRL_RESET[irq_ctl_pkg::PORT_FLAG_BIT];
    end else if (mismatch) begin
      port_flag_q <= 1'b1;
    end else if (wr_ctrl) begin
      port_flag_q <= link.reg_wdata[irq_ctl_pkg::PORT_FLAG_BIT];
    end
  end

  // Reading the port snapshots pins and ends the mismatch
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_read_q <= 4'h0;
    end else if (rd_port) begin
      last_read_q <= port_s;
    end
  end

  // ----------------------------------------------------------------
  // Second register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      edge_prio_q <= irq_ctl_pkg::EDGE_PRIO_RESET;
    end else if (wr_edge) begin
      edge_prio_q <= link.reg_wdata;
    end
  end

  assign port_pullup_disable_o = edge_prio_q[irq_ctl_pkg::PULLUP_BIT];

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Data appears the cycle after the read strobe
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= 8'h00;
    end else if (link.reg_rd) begin
      case (link.reg_sel)
        irq_ctl_pkg::SEL_CTRL: begin
          rdata_q <= {enable_q, timer_flag_q, ext0_flag_q, port_flag_q};
        end
        irq_ctl_pkg::SEL_EDGE: begin
          rdata_q <= edge_prio_q;
        end
        irq_ctl_pkg::SEL_PORT: begin
          rdata_q <= {port_s, 4'h0};
        end
        default: begin
          rdata_q <= 8'h00;
        end
      endcase
    end
  end

  assign link.reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Request evaluation
  // ----------------------------------------------------------------
  logic gie_high;
  logic peie_low;
  logic act_timer;
  logic act_ext0;
  logic act_port;
  logic hi_act;
  logic lo_act;
  logic req_high;
  logic req_low;

  assign gie_high = enable_q[irq_ctl_pkg::GLOBAL_HIGH_BIT-3];
  assign peie_low = enable_q[irq_ctl_pkg::PERIPH_LOW_BIT-3];
  assign act_timer = enable_q[irq_ctl_pkg::TIMER_EN_BIT-3] && timer_flag_q;
  assign act_ext0 = enable_q[irq_ctl_pkg::EXT0_EN_BIT-3] && ext0_flag_q;
  assign act_port = enable_q[irq_ctl_pkg::PORT_EN_BIT-3] && port_flag_q;

  // Pin zero has no priority bit and is always high
  assign hi_act = (act_timer && edge_prio_q[irq_ctl_pkg::TIMER_PRIO_BIT])
                || act_ext0
                || (act_port && edge_prio_q[irq_ctl_pkg::PORT_PRIO_BIT])
                || (periph_req_i && periph_high_i);
  assign lo_act = (act_timer && !edge_prio_q[irq_ctl_pkg::TIMER_PRIO_BIT])
                || (act_port && !edge_prio_q[irq_ctl_pkg::PORT_PRIO_BIT])
                || (periph_req_i && !periph_high_i);

  // Compatibility mode ignores priority bits and uses the high vector
  always_comb begin
    if (!link.priority_mode_enable) begin
      req_high = gie_high && (act_timer || act_ext0 || act_port
                 || (peie_low && periph_req_i));
      req_low = 1'b0;
    end else begin
      req_high = gie_high && hi_act;
      req_low = gie_high && peie_low && lo_act;
    end
  end

  // Registered toward the core; high priority wins the vector
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_high_q <= 1'b0;
      irq_low_q <= 1'b0;
      vector_q <= irq_ctl_pkg::VEC_NONE;
    end else begin
      irq_high_q <= req_high;
      irq_low_q <= req_low;
      if (req_high) begin
        vector_q <= irq_ctl_pkg::VEC_HIGH;
      end else if (req_low) begin
        vector_q <= irq_ctl_pkg::VEC_LOW;
      end else begin
        vector_q <= irq_ctl_pkg::VEC_NONE;
      end
    end
  end

  assign link.irq_high = irq_high_q;
  assign link.irq_low = irq_low_q;
  assign link.irq_vector = vector_q;

endmodule
`default_nettype wire

// [logic/irq_host_ctrl.sv]
// AHB-Lite controller that drives the interrupt register block
`timescale 1ns/1ns
`default_nettype none
module irq_host_ctrl (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic irq_o,
  intr_link_if.host_mp link
);

  // Device windows and their select codes
  function automatic logic is_dev(input logic [7:0] ofs);
    return (ofs == irq_ctl_pkg::OFS_CTRL_WIN) || (ofs == irq_ctl_pkg::OFS_EDGE_WIN)
        || (ofs == irq_ctl_pkg::OFS_PORT_RD);
  endfunction

  function automatic logic [1:0] dev_sel(input logic [7:0] ofs);
    case (ofs)
      irq_ctl_pkg::OFS_EDGE_WIN: dev_sel = irq_ctl_pkg::SEL_EDGE;
      irq_ctl_pkg::OFS_PORT_RD: dev_sel = irq_ctl_pkg::SEL_PORT;
      default: dev_sel = irq_ctl_pkg::SEL_CTRL;
    endcase
  endfunction

  irq_ctl_pkg::bus_state_e state_q;
  logic [7:0] addr_q;
  logic mode_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic high_prev_q;
  logic low_prev_q;
  logic accept;
  logic do_write;
  logic [31:0] loc_rdata;

  assign accept = hsel_i && (htrans_i == irq_ctl_pkg::HTRANS_NONSEQ) && hready_i
                  && (state_q == irq_ctl_pkg::ST_IDLE);
  assign do_write = (state_q == irq_ctl_pkg::ST_WRITE);
  assign hresp_o = 1'b0;

  // ----------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------
  // Writes take one wait so hwdata lands before the next request
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= irq_ctl_pkg::ST_IDLE;
      hreadyout_o <= 1'b1;
      addr_q <= 8'h00;
    end else begin
      case (state_q)
        irq_ctl_pkg::ST_IDLE: begin
          if (accept) begin
            addr_q <= haddr_i[7:0];
            if (hwrite_i) begin
              state_q <= irq_ctl_pkg::ST_WRITE;
              hreadyout_o <= 1'b0;
            end else if (is_dev(haddr_i[7:0])) begin
              state_q <= irq_ctl_pkg::ST_RD_REQ;
              hreadyout_o <= 1'b0;
            end
          end
        end
        irq_ctl_pkg::ST_WRITE: begin
          state_q <= irq_ctl_pkg::ST_IDLE;
          hreadyout_o <= 1'b1;
        end
        irq_ctl_pkg::ST_RD_REQ: begin
          state_q <= irq_ctl_pkg::ST_RD_WAIT;
        end
        irq_ctl_pkg::ST_RD_WAIT: begin
          state_q <= irq_ctl_pkg::ST_IDLE;
          hreadyout_o <= 1'b1;
        end
        default: begin
          state_q <= irq_ctl_pkg::ST_IDLE;
          hreadyout_o <= 1'b1;
        end
      endcase
    end
  end

  // Link strobes, one cycle each
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      link.reg_sel <= irq_ctl_pkg::SEL_CTRL;
      link.reg_wdata <= 8'h00;
    end else begin
      link.reg_wr <= do_write && is_dev(addr_q);
      link.reg_rd <= accept && !hwrite_i && is_dev(haddr_i[7:0]);
      if (accept) begin
        link.reg_sel <= dev_sel(haddr_i[7:0]);
      end
      if (do_write) begin
        link.reg_wdata <= hwdata_i[7:0];
      end
    end
  end

  // Local read mux; unmapped offsets read zero
  always_comb begin
    case (haddr_i[7:0])
      irq_ctl_pkg::OFS_MODE: loc_rdata = {31'h0, mode_q};
      irq_ctl_pkg::OFS_STATUS: loc_rdata = {30'h0, status_q};
      irq_ctl_pkg::OFS_MASK: loc_rdata = {30'h0, mask_q};
      irq_ctl_pkg::OFS_VECTOR: loc_rdata = {16'h0, link.irq_vector};
      default: loc_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hrdata_o <= 32'h0;
    end else if (state_q == irq_ctl_pkg::ST_RD_WAIT) begin
      hrdata_o <= {24'h0, link.reg_rdata};
    end else if (accept && !hwrite_i) begin
      hrdata_o <= loc_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Own registers: mode, status, mask
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_q <= 1'b0;
      mask_q <= irq_ctl_pkg::MASK_RESET;
    end else if (do_write) begin
      if (addr_q == irq_ctl_pkg::OFS_MODE) begin
        mode_q <= hwdata_i[0];
      end
      if (addr_q == irq_ctl_pkg::OFS_MASK) begin
        mask_q <= hwdata_i[1:0];
      end
    end
  end

  assign link.priority_mode_enable = mode_q;

  // Rising request edges set sticky bits; set beats write-one-clear
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      high_prev_q <= 1'b0;
      low_prev_q <= 1'b0;
      status_q <= irq_ctl_pkg::STATUS_RESET;
      irq_o <= 1'b0;
    end else begin
      high_prev_q <= link.irq_high;
      low_prev_q <= link.irq_low;
      if (do_write && (addr_q == irq_ctl_pkg::OFS_STATUS)) begin
        status_q <= (status_q & ~hwdata_i[1:0])
                    | {link.irq_low && !low_prev_q, link.irq_high && !high_prev_q};
      end else begin
        status_q <= status_q
                    | {link.irq_low && !low_prev_q, link.irq_high && !high_prev_q};
      end
      irq_o <= |(status_q & mask_q);
    end
  end

endmodule
`default_nettype wire

// [bench/irq_link_props.sv]
// Concurrent checks on the register link between controller and device
`timescale 1ns/1ns
`default_nettype none
module irq_link_props (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic priority_mode_enable,
  input wire logic [1:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic irq_high,
  input wire logic irq_low,
  input wire logic [15:0] irq_vector
);
  logic [7:0] ctrl_q;
  logic [7:0] edge_q;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  // Shadow of the last software write; flags are left out of compares
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q <= irq_ctl_pkg::CTRL_RESET;
    end else if (reg_wr && reg_sel == irq_ctl_pkg::SEL_CTRL) begin
      ctrl_q <= reg_wdata;
    end
  end

  // Second register has no hardware-set bits, so the shadow is exact
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      edge_q <= irq_ctl_pkg::EDGE_PRIO_RESET;
    end else if (reg_wr && reg_sel == irq_ctl_pkg::SEL_EDGE) begin
      edge_q <= reg_wdata;
    end
  end

  // ------------------------------------------------------------
  // Steps of an enable write and its effect
  // ------------------------------------------------------------
  sequence s_ctrl_wr;
    reg_wr && reg_sel == irq_ctl_pkg::SEL_CTRL;
  endsequence
  sequence s_blocked;
    ##1 (!irq_high && !irq_low) [*2];
  endsequence
  sequence s_low_blocked;
    ##1 (!irq_low) [*2];
  endsequence

  a_vec_high: assert property (irq_high |-> irq_vector == irq_ctl_pkg::VEC_HIGH)
    else $error("high request without high vector");
  a_vec_low: assert property (irq_low && !irq_high |-> irq_vector == irq_ctl_pkg::VEC_LOW)
    else $error("low request without low vector");
  a_vec_idle: assert property (!irq_high && !irq_low |-> irq_vector == irq_ctl_pkg::VEC_NONE)
    else $error("vector shown with no request");
  a_compat_no_low: assert property (!priority_mode_enable [*2] |-> !irq_low)
    else $error("low request in compatibility mode");
  a_global_off_blocks: assert property (s_ctrl_wr ##0 !reg_wdata[7] |=> s_blocked)
    else $error("request survives global enable clear");
  a_low_off_blocks: assert property (s_ctrl_wr ##0 !reg_wdata[6] |=> s_low_blocked)
    else $error("low request survives low enable clear");
  a_high_needs_global: assert property (irq_high |-> $past(ctrl_q[7]))
    else $error("high request with global enable clear");
  a_low_needs_both: assert property (irq_low |-> $past(ctrl_q[7]) && $past(ctrl_q[6]))
    else $error("low request without both enables");
  a_ctrl_readback: assert property (
    reg_rd && reg_sel == irq_ctl_pkg::SEL_CTRL |=> reg_rdata[7:3] == ctrl_q[7:3])
    else $error("enable bits read back wrong");
  a_edge_readback: assert property (
    reg_rd && reg_sel == irq_ctl_pkg::SEL_EDGE |=> reg_rdata == edge_q)
    else $error("edge and priority bits read back wrong");
endmodule
`default_nettype wire

// [bench/core_interrupt_control_regs_tb.sv]
// Self-checking bench for the interrupt register block and its controller
`timescale 1ns/1ns
`default_nettype none
module core_interrupt_control_regs_tb;
  localparam logic [7:0] CTL = irq_ctl_pkg::OFS_CTRL_WIN;
  localparam logic [7:0] EDG = irq_ctl_pkg::OFS_EDGE_WIN;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic irq;
  logic timer_ovf = 1'b0;
  logic [3:0] ext_pin = 4'h0;
  logic [3:0] port_pins = 4'h0;
  logic periph_req = 1'b0;
  logic periph_high = 1'b0;
  logic [2:0] ext_edge;
  logic pullup_dis;
  logic [31:0] rd;
  logic [19:0] row;
  // Row: {mode, periph, high, low} nibble, then edge byte, then enable byte
  logic [19:0] tbl [14] = '{20'h2FBA4, 20'h0FF24, 20'h0FF84, 20'h2FF92, 20'h0FF82,
    20'h2FF89, 20'h0FF81, 20'h6FFC0, 20'h4FF80, 20'h9FBE4, 20'h8FBA4, 20'h8FF64,
    20'hAFFA4, 20'hDFFC0};
  int n_fail = 0;
  int num_checks = 0;
  int n;

  intr_link_if link ();

  core_interrupt_control_regs core_interrupt_control_regs_inst (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .link(link), .timer_ovf_i(timer_ovf), .ext_pin_i(ext_pin),
    .upper_port_pins_i(port_pins), .periph_req_i(periph_req), .periph_high_i(periph_high),
    .ext_edge_o(ext_edge), .port_pullup_disable_o(pullup_dis));

  irq_host_ctrl irq_host_ctrl_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .irq_o(irq), .link(link));

  irq_link_props irq_link_props_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .priority_mode_enable(link.priority_mode_enable), .reg_sel(link.reg_sel),
    .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_wdata(link.reg_wdata),
    .reg_rdata(link.reg_rdata), .irq_high(link.irq_high), .irq_low(link.irq_low),
    .irq_vector(link.irq_vector));

  // ------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ------------------------------------------------------------
  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  // A hung handshake would otherwise stall the run forever
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    give_verdict();
  end

  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_i);
  endtask

  // Single word transfer; address held until taken, data until done
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= irq_ctl_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge ref_clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    tick(2);
    reset_n_i <= 1'b1;
    tick(1);
    check(pullup_dis, 32'h1);
    rdc(CTL, 32'h00);
    rdc(EDG, 32'hFF);
    // Timer overflow with every enable off still sets a sticky flag
    timer_ovf <= 1'b1;
    tick(1);
    timer_ovf <= 1'b0;
    tick(3);
    rdc(CTL, 32'h04);
    check(link.irq_high, 32'h0);
    rdc(CTL, 32'h04);
    bus(1'b1, CTL, 32'h00);
    // Pin zero: rising selected, then falling selected
    ext_pin <= 4'h1;
    tick(6);
    rdc(CTL, 32'h02);
    bus(1'b1, CTL, 32'h00);
    tick(6);
    rdc(CTL, 32'h00);
    ext_pin <= 4'h0;
    tick(6);
    rdc(CTL, 32'h00);
    bus(1'b1, EDG, 32'hBF);
    ext_pin <= 4'h1;
    tick(6);
    rdc(CTL, 32'h00);
    ext_pin <= 4'h0;
    tick(6);
    rdc(CTL, 32'h02);
    bus(1'b1, CTL, 32'h00);
    // Port change: flag cannot clear until the port is read
    port_pins <= 4'h2;
    tick(6);
    rdc(CTL, 32'h01);
    bus(1'b1, CTL, 32'h00);
    rdc(CTL, 32'h01);
    rdc(irq_ctl_pkg::OFS_PORT_RD, 32'h20);
    bus(1'b1, CTL, 32'h00);
    rdc(CTL, 32'h00);
    // Pin three rising edge gives exactly one exported pulse
    ext_pin <= 4'h8;
    n = 0;
    repeat (10) begin
      @(posedge ref_clk_i);
      if (ext_edge[2] === 1'b1) n++;
    end
    check(n, 32'h1);
    // Enable and mode combinations
    foreach (tbl[i]) begin
      row = tbl[i];
      periph_req <= row[18];
      bus(1'b1, irq_ctl_pkg::OFS_MODE, {31'h0, row[19]});
      bus(1'b1, EDG, {24'h0, row[15:8]});
      bus(1'b1, CTL, {24'h0, row[7:0]});
      tick(4);
      check(link.irq_high, row[17]);
      check(link.irq_low, row[16]);
      check(link.irq_vector, row[17] ? irq_ctl_pkg::VEC_HIGH :
        (row[16] ? irq_ctl_pkg::VEC_LOW : irq_ctl_pkg::VEC_NONE));
      rdc(CTL, {24'h0, row[7:0]});
    end
    // Peripheral marked high moves to the high request in priority mode
    periph_high <= 1'b1;
    tick(3);
    check(link.irq_high, 32'h1);
    check(link.irq_low, 32'h0);
    periph_high <= 1'b0;
    tick(3);
    rdc(irq_ctl_pkg::OFS_VECTOR, {16'h0, irq_ctl_pkg::VEC_LOW});
    rdc(irq_ctl_pkg::OFS_MODE, 32'h1);
    check(hresp, 32'h0);
    // Status, mask and interrupt line; low request still active here
    rdc(irq_ctl_pkg::OFS_STATUS, 32'h3);
    check(irq, 32'h0);
    bus(1'b1, irq_ctl_pkg::OFS_MASK, 32'h1);
    tick(3);
    check(irq, 32'h1);
    bus(1'b1, irq_ctl_pkg::OFS_STATUS, 32'h1);
    tick(3);
    check(irq, 32'h0);
    rdc(irq_ctl_pkg::OFS_STATUS, 32'h2);
    // Pull-up disable bit follows the second register's top bit
    bus(1'b1, EDG, 32'h7F);
    tick(1);
    check(pullup_dis, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
